// [power_mode_pkg.sv]
// shared constants and types for the power mode and frame timing block
package power_mode_pkg;

    // operating modes, two-bit state
    typedef enum logic [1:0] {
        MODE_POWERED,
        MODE_BATTERY_RUN,
        MODE_DISPLAY_ONLY,
        MODE_SLEEP
    } op_mode_t;

    // frame sequencer states
    typedef enum logic [1:0] {
        FRAME_CONVERT,
        FRAME_SETTLE,
        FRAME_GAP
    } frame_state_t;

    // special register holding the power event flags
    localparam logic [7:0] POWER_EVENT_FLAGS_ADDR = 8'he8;
    localparam int         PLL_FALL_BIT           = 7;
    localparam int         PLL_RISE_BIT           = 6;
    localparam int         TIMER_WAKE_BIT         = 5;
    localparam int         BUTTON_WAKE_BIT        = 4;
    localparam logic [7:0] POWER_EVENT_FLAGS_RST  = 8'h00;

    // clock rate and crystal rate
    localparam int CLK_HZ        = 125000000;
    localparam int CRYSTAL_HZ    = 32768;
    // one crystal tick every so many clk cycles (rounded down)
    localparam int CRYSTAL_DIV   = CLK_HZ / CRYSTAL_HZ;
    // processor clock in battery run: 7 of every 8 crystal ticks
    localparam logic [2:0] BATTERY_SKIP_PHASE = 3'h7;

    // pll settle window after supply return, in crystal ticks
    localparam int PLL_SETTLE_MIN = 2048;
    localparam int PLL_SETTLE_MAX = 4096;

    // processor restart after wake, crystal ticks
    localparam int WAKE_START_TICKS = 3;

    // realtime monitor stream length in fast cycles
    localparam int MONITOR_BITS = 140;

    // engine cycle counts per filter length (0, 1, 2)
    localparam int ENGINE_CYCLES_0 = 138;
    localparam int ENGINE_CYCLES_1 = 288;
    localparam int ENGINE_CYCLES_2 = 384;

    localparam logic [15:0] RESTART_ADDR = 16'h0000;
    localparam int          KEEP_REGS    = 8;

    // supply and sensing inputs
    typedef struct packed {
        logic system_supply;
        logic fault_above_bias;   // fault_sense_input above bias_reference
        logic battery_present;
        logic battery_headroom_ok;
        logic pll_locked;
    } supply_status_t;

    // firmware control bits
    typedef struct packed {
        logic       display_only_request;
        logic       sleep_request;
        logic       adc_enable_bit;
        logic       engine_enable_bit;
        logic [2:0] processor_clock_divider;
        logic [3:0] mux_slot_divider;
        logic [1:0] filter_length_select;
        logic [1:0] first_slot_select;
        logic [7:0] presample_count;
        logic [7:0] accum_cycle_count;
    } fw_control_t;

    // gated enables toward the rest of the chip
    typedef struct packed {
        logic processor_run;
        logic processor_clk_en;
        logic adc_enable;
        logic engine_enable;
        logic display_enable;
        logic serial_enable;
        logic measure_enable;
    } gate_out_t;

endpackage

// [meter_power_mode_and_frame_timing.sv]
// power mode controller with clock gating and sampling frame sequencer
//
// Summary of operation
// - frame lasts 1 plus divider times k ticks
// - whole-tick conversion then one settle tick
// - engine pass starts with slot 0 conversion
// - result written when each conversion completes
// - monitor stream starts at S, 140 cycles
// - transfer busy every presamples times accumulations
// - powered mode needs supply and stable pll
// - battery run on fault drop or wake
// - firmware requests display-only or sleep from battery
// - pll fall and rise set flags 7, 6
// - wake only by supply, timer, button; flags
// - low headroom forces sleep, stays asleep
// - supply return goes powered after pll settles
// - battery run processor clock is seven eighths
// - divider kept, ignored during battery run
// - no pll lock forces adc and engine enables off, clears pc
// - display-only stops processor, segments keep showing
// - wake restarts at zero, data memory undefined
// - eight keep registers survive sleep and display
// - sleep keeps only crystal and clock
// - battery run clock still serves 300 bd
// - processor held until pll lock after return
// - battery to powered raises interrupt, keeps config
// - button wake starts processor within three ticks
`timescale 1ns/1ps
module meter_power_mode_and_frame_timing
    import power_mode_pkg::*;
(
    // clock and reset
    input  wire logic                         clk,
    input  wire logic                         reset,
    // supply sensing and wake sources
    input  wire power_mode_pkg::supply_status_t supply,
    input  wire logic                         button_input,
    input  wire logic                         wake_timer_expired,
    // firmware control bits
    input  wire power_mode_pkg::fw_control_t  ctrl,
    // special register port
    input  wire logic [7:0]                   sfr_addr,
    input  wire logic                         sfr_write,
    input  wire logic [7:0]                   sfr_wdata,
    input  wire logic                         sfr_read,
    output logic [7:0]                        sfr_rdata,
    // keep registers port
    input  wire logic [2:0]                   keep_sel,
    input  wire logic                         keep_write,
    input  wire logic [7:0]                   keep_wdata,
    output logic [7:0]                        keep_rdata,
    // mode and gating
    output power_mode_pkg::op_mode_t          mode,
    output power_mode_pkg::gate_out_t         gates,
    output logic                              mode_change_irq,
    output logic [15:0]                       restart_pc,
    output logic                              data_mem_invalid,
    // frame timing
    output logic                              engine_pass_start,
    output logic                              result_write,
    output logic [1:0]                        result_slot,
    output logic                              engine_pc_clear,
    output logic                              monitor_active,
    output logic                              transfer_busy
);
    import power_mode_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // crystal tick divider: the only slow rate, a one-cycle enable
    localparam int DIV_W = $clog2(CRYSTAL_DIV);
    logic [DIV_W-1:0] div_reg;
    logic             tick;
    always_ff @(posedge clk) begin
        if (reset || div_reg == DIV_W'(CRYSTAL_DIV - 1)) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_reg + 1'b1;
        end
    end
    assign tick = (div_reg == DIV_W'(CRYSTAL_DIV - 1));

    ////////////////////////////////////////////////////////////////////////////
    // input edge history
    logic button_prev_reg;
    logic pll_prev_reg;
    logic button_rise;
    logic pll_fall;
    always_ff @(posedge clk) begin
        if (reset) begin
            button_prev_reg <= 1'b0;
            pll_prev_reg    <= 1'b0;
        end else begin
            button_prev_reg <= button_input;
            pll_prev_reg    <= supply.pll_locked;
        end
    end
    assign button_rise = button_input && !button_prev_reg;
    assign pll_fall    = pll_prev_reg && !supply.pll_locked;

    ////////////////////////////////////////////////////////////////////////////
    // supply return: count ticks since supply came back, saturating at the top of the settle window
    localparam int SETTLE_W = $clog2(PLL_SETTLE_MAX + 1);
    logic [SETTLE_W-1:0] settle_reg;
    logic                settle_ok;
    always_ff @(posedge clk) begin
        if (reset || !supply.system_supply) begin
            settle_reg <= '0;
        end else if (tick && settle_reg != SETTLE_W'(PLL_SETTLE_MAX)) begin
            settle_reg <= settle_reg + 1'b1;
        end
    end
    // pll is trusted no earlier than the minimum window
    assign settle_ok = supply.pll_locked && settle_reg >= SETTLE_W'(PLL_SETTLE_MIN);

    ////////////////////////////////////////////////////////////////////////////
    // mode state machine
    op_mode_t mode_reg;
    op_mode_t mode_next;
    logic     powered_ok;
    logic     low_headroom;
    assign powered_ok   = supply.system_supply && supply.fault_above_bias && settle_ok;
    assign low_headroom = !supply.battery_headroom_ok;
    always_comb begin
        mode_next = mode_reg;
        case (mode_reg)
            MODE_POWERED: begin
                if (!supply.fault_above_bias || !supply.pll_locked) begin
                    // battery present with headroom keeps running, otherwise straight to sleep
                    mode_next = (supply.battery_present && !low_headroom)
                              ? MODE_BATTERY_RUN : MODE_SLEEP;
                end
            end
            MODE_BATTERY_RUN: begin
                if (powered_ok) begin
                    mode_next = MODE_POWERED;
                end else if (low_headroom) begin
                    mode_next = MODE_SLEEP;
                end else if (ctrl.sleep_request) begin
                    mode_next = MODE_SLEEP;
                end else if (ctrl.display_only_request) begin
                    mode_next = MODE_DISPLAY_ONLY;
                end
            end
            MODE_DISPLAY_ONLY, MODE_SLEEP: begin
                // wakes only on supply, timer or button; headroom alone never wakes
                if (powered_ok) begin
                    mode_next = MODE_POWERED;
                end else if ((wake_timer_expired || button_rise) && !low_headroom) begin
                    mode_next = MODE_BATTERY_RUN;
                end else if (low_headroom) begin
                    mode_next = MODE_SLEEP;
                end
            end
            default: mode_next = MODE_SLEEP;
        endcase
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            mode_reg <= MODE_POWERED;
        end else begin
            mode_reg <= mode_next;
        end
    end
    assign mode = mode_reg;

    logic leaving_low;
    assign leaving_low = (mode_reg == MODE_DISPLAY_ONLY || mode_reg == MODE_SLEEP)
                       && mode_next != mode_reg && mode_next != MODE_SLEEP;

    ////////////////////////////////////////////////////////////////////////////
    // power event flags; hardware set wins over a firmware clear
    logic [7:0] flags_reg;
    logic [7:0] flag_set;
    logic       flags_wr;
    always_comb begin
        flag_set = 8'h00;
        flag_set[PLL_FALL_BIT]    = mode_reg == MODE_POWERED && mode_next == MODE_BATTERY_RUN;
        flag_set[PLL_RISE_BIT]    = mode_reg != MODE_POWERED && mode_next == MODE_POWERED;
        flag_set[TIMER_WAKE_BIT]  = leaving_low && wake_timer_expired;
        flag_set[BUTTON_WAKE_BIT] = leaving_low && button_rise;
    end
    assign flags_wr = sfr_write && sfr_addr == POWER_EVENT_FLAGS_ADDR;
    always_ff @(posedge clk) begin
        if (reset) begin
            flags_reg <= POWER_EVENT_FLAGS_RST;
        end else begin
            // firmware writes zero to clear; unused bits read zero
            flags_reg <= ((flags_wr ? (flags_reg & sfr_wdata) : flags_reg) | flag_set)
                       & 8'hf0;
        end
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_read && sfr_addr == POWER_EVENT_FLAGS_ADDR) begin
            sfr_rdata <= flags_reg;
        end else begin
            sfr_rdata <= 8'h00;
        end
    end
    // interrupt on dropping from powered to battery run or returning to powered
    always_ff @(posedge clk) begin
        if (reset) begin
            mode_change_irq <= 1'b0;
        end else begin
            mode_change_irq <= flag_set[PLL_FALL_BIT] || flag_set[PLL_RISE_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // keep registers: cleared only by hardware reset, never by mode changes
    logic [7:0] keep_reg [KEEP_REGS];
    genvar gi;
    generate
        for (gi = 0; gi < KEEP_REGS; gi++) begin : g_keep
            always_ff @(posedge clk) begin
                if (reset) begin
                    keep_reg[gi] <= 8'h00;
                end else if (keep_write && keep_sel == 3'(gi)) begin
                    keep_reg[gi] <= keep_wdata;
                end
            end
        end
    endgenerate
    always_ff @(posedge clk) begin
        if (reset) begin
            keep_rdata <= 8'h00;
        end else begin
            keep_rdata <= keep_reg[keep_sel];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // wake restart: processor held a few ticks, then restarts at zero
    logic [1:0] wake_cnt_reg;
    logic       held_reg;
    always_ff @(posedge clk) begin
        if (reset) begin
            wake_cnt_reg     <= '0;
            held_reg         <= 1'b0;
            restart_pc       <= RESTART_ADDR;
            data_mem_invalid <= 1'b0;
        end else if (leaving_low) begin
            wake_cnt_reg     <= 2'(WAKE_START_TICKS - 1);
            held_reg         <= 1'b1;
            restart_pc       <= RESTART_ADDR;
            data_mem_invalid <= 1'b1;
        end else if (held_reg && tick) begin
            // release within three ticks of the wake edge
            if (wake_cnt_reg == 2'h0) begin
                held_reg <= 1'b0;
            end else begin
                wake_cnt_reg <= wake_cnt_reg - 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // processor clock: divider in powered, 7 of 8 crystal ticks on battery
    logic [2:0] skip_reg;
    logic [2:0] pdiv_reg;
    logic       proc_en;
    always_ff @(posedge clk) begin
        if (reset) begin
            skip_reg <= '0;
        end else if (tick) begin
            skip_reg <= skip_reg + 1'b1;
        end
    end
    always_ff @(posedge clk) begin
        if (reset || pdiv_reg >= ctrl.processor_clock_divider) begin
            pdiv_reg <= '0;
        end else if (mode_reg == MODE_POWERED) begin
            pdiv_reg <= pdiv_reg + 1'b1;
        end
    end
    always_comb begin
        case (mode_reg)
            MODE_POWERED:     proc_en = pdiv_reg >= ctrl.processor_clock_divider;
            // jittery but averages 28.672 kHz, enough for 300 bd serial
            MODE_BATTERY_RUN: proc_en = tick && skip_reg != BATTERY_SKIP_PHASE;
            default:          proc_en = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // enable gating per mode
    logic run_ok;
    assign run_ok = (mode_reg == MODE_POWERED || mode_reg == MODE_BATTERY_RUN) && !held_reg;
    always_ff @(posedge clk) begin
        if (reset) begin
            gates <= '0;
        end else begin
            gates.processor_run    <= run_ok && (mode_reg != MODE_POWERED || settle_ok);
            gates.processor_clk_en <= run_ok && proc_en;
            gates.adc_enable       <= ctrl.adc_enable_bit && supply.pll_locked
                                      && mode_reg == MODE_POWERED;
            gates.engine_enable    <= ctrl.engine_enable_bit && supply.pll_locked
                                      && mode_reg == MODE_POWERED;
            gates.display_enable   <= mode_reg != MODE_SLEEP;
            gates.serial_enable    <= mode_reg == MODE_POWERED || mode_reg == MODE_BATTERY_RUN;
            gates.measure_enable   <= mode_reg == MODE_POWERED;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // frame sequencer: k conversion ticks per slot, then one settle tick per frame
    frame_state_t fstate_reg;
    logic [1:0]   k_ticks;
    logic [1:0]   conv_cnt_reg;
    logic [3:0]   slot_reg;
    logic         frame_run;
    assign k_ticks   = (ctrl.filter_length_select == 2'h2) ? 2'h3
                     : (ctrl.filter_length_select == 2'h1) ? 2'h2 : 2'h1;
    assign frame_run = gates.adc_enable;
    always_ff @(posedge clk) begin
        if (reset || !frame_run) begin
            fstate_reg   <= FRAME_GAP;
            conv_cnt_reg <= '0;
            slot_reg     <= '0;
        end else if (tick) begin
            case (fstate_reg)
                FRAME_GAP, FRAME_SETTLE: begin
                    // idle start or the settle tick: next frame opens at slot 0
                    fstate_reg   <= FRAME_CONVERT;
                    slot_reg     <= '0;
                    conv_cnt_reg <= k_ticks - 2'h1;
                end
                FRAME_CONVERT: begin
                    if (conv_cnt_reg != 2'h0) begin
                        conv_cnt_reg <= conv_cnt_reg - 2'h1;
                    end else if (slot_reg + 4'h1 < ctrl.mux_slot_divider) begin
                        slot_reg     <= slot_reg + 4'h1;
                        conv_cnt_reg <= k_ticks - 2'h1;
                    end else begin
                        fstate_reg <= FRAME_SETTLE;
                    end
                end
                default: fstate_reg <= FRAME_GAP;
            endcase
        end
    end
    // crossing flips once per frame, so a single settle tick closes it: 1 + slots * k

    ////////////////////////////////////////////////////////////////////////////
    // frame events, engine pass, monitor stream, transfer busy
    logic       pass_begin;
    logic       conv_done;
    logic [7:0] mon_cnt_reg;
    logic [7:0] pre_cnt_reg;
    logic [7:0] acc_cnt_reg;
    // slot 0 conversion starts on any tick outside the convert state while frame_run is high
    assign pass_begin = tick && frame_run && fstate_reg != FRAME_CONVERT;
    assign conv_done  = tick && frame_run && fstate_reg == FRAME_CONVERT
                      && conv_cnt_reg == 2'h0;
    always_ff @(posedge clk) begin
        if (reset) begin
            engine_pass_start <= 1'b0;
            result_write      <= 1'b0;
            result_slot       <= '0;
            engine_pc_clear   <= 1'b0;
        end else begin
            // pass begins with the conversion of the selected first slot
            engine_pass_start <= pass_begin;
            result_write      <= conv_done;
            result_slot       <= slot_reg[1:0] + ctrl.first_slot_select;
            engine_pc_clear   <= pll_fall;
        end
    end
    // monitor stream runs 140 fast cycles from pass start, well inside a frame
    always_ff @(posedge clk) begin
        if (reset || pll_fall) begin
            mon_cnt_reg    <= '0;
            monitor_active <= 1'b0;
        end else if (pass_begin) begin
            mon_cnt_reg    <= 8'(MONITOR_BITS - 1);
            monitor_active <= 1'b1;
        end else if (mon_cnt_reg != 8'h00) begin
            mon_cnt_reg <= mon_cnt_reg - 8'h01;
        end else begin
            monitor_active <= 1'b0;
        end
    end
    // one pulse per presample_count times accum_cycle_count passes
    always_ff @(posedge clk) begin
        if (reset || pll_fall) begin
            pre_cnt_reg   <= '0;
            acc_cnt_reg   <= '0;
            transfer_busy <= 1'b0;
        end else begin
            transfer_busy <= 1'b0;
            if (pass_begin) begin
                if (pre_cnt_reg + 8'h01 >= ctrl.presample_count) begin
                    pre_cnt_reg <= '0;
                    if (acc_cnt_reg + 8'h01 >= ctrl.accum_cycle_count) begin
                        acc_cnt_reg   <= '0;
                        transfer_busy <= 1'b1;
                    end else begin
                        acc_cnt_reg <= acc_cnt_reg + 8'h01;
                    end
                end else begin
                    pre_cnt_reg <= pre_cnt_reg + 8'h01;
                end
            end
        end
    end

endmodule

// [power_mode_assertions.sv]
// concurrent checks on the power mode block ports
`timescale 1ns/1ps
module power_mode_assertions
    import power_mode_pkg::*;
(
    // clock, reset and causes
    input wire logic clk,
    input wire logic reset,
    input wire power_mode_pkg::supply_status_t supply,
    input wire logic button_input,
    input wire logic wake_timer_expired,
    // watched outputs
    input wire logic [7:0] sfr_rdata,
    input wire power_mode_pkg::op_mode_t mode,
    input wire power_mode_pkg::gate_out_t gates,
    input wire logic mode_change_irq,
    input wire logic engine_pc_clear
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (reset);
    // lock loss must stop the engine at once, not at frame end
    a_pc_clear: assert property ($fell(supply.pll_locked) |=> engine_pc_clear)
        else $error("engine pc not cleared after lock loss");
    a_lock_gates: assert property (!supply.pll_locked [*2] |->
        !gates.adc_enable && !gates.engine_enable) else $error("enables live without lock");
    a_irq_on_fall: assert property ($past(mode) == MODE_POWERED
        && mode == MODE_BATTERY_RUN |-> ##[0:1] mode_change_irq) else $error("no mode irq");
    // only supply, timer or button may end sleep
    a_sleep_holds: assert property (mode == MODE_SLEEP && !supply.system_supply
        && !wake_timer_expired && !button_input && !$past(button_input)
        && !$past(wake_timer_expired) |=> mode == MODE_SLEEP) else $error("sleep left");
    a_no_req_powered: assert property (mode == MODE_POWERED |=>
        mode != MODE_DISPLAY_ONLY) else $error("display entered from powered");
    a_sleep_gates: assert property (mode == MODE_SLEEP [*2] |-> !gates.processor_run
        && !gates.display_enable && !gates.serial_enable) else $error("sleep gates on");
    a_display_stop: assert property (mode == MODE_DISPLAY_ONLY [*2] |->
        !gates.processor_run && gates.display_enable) else $error("display gates wrong");
    a_battery_meter: assert property (mode != MODE_POWERED [*2] |->
        !gates.measure_enable) else $error("measuring off mains");
    a_flag_nibble: assert property (sfr_rdata[3:0] == 4'h0)
        else $error("reserved flag bits set");
endmodule
bind meter_power_mode_and_frame_timing power_mode_assertions u_power_mode_assertions (.*);

// [firmware_model.sv]
// firmware stand-in: control bits out, wake cause decoded from flags
`timescale 1ns/1ps
module firmware_model
    import power_mode_pkg::*;
(
    // requests and last flag read
    input wire logic want_display,
    input wire logic want_sleep,
    input wire logic [7:0] flags,
    input wire logic comparator_status,
    // control bits and decoded cause
    output power_mode_pkg::fw_control_t ctrl,
    output logic [1:0] wake_cause
);
    // short frame (one slot, shortest filter) keeps the run brief
    assign ctrl = {want_display, want_sleep, 2'h3, 3'h2, 4'h1, 2'h0, 2'h0, 8'h02, 8'h01};
    // timer first, then button, then reset without mains, else supply
    assign wake_cause = flags[5] ? 2'h0 : flags[4] ? 2'h1 : !comparator_status ? 2'h2 : 2'h3;
endmodule

// [tb_top.sv]
// self-checking bench for the power mode and frame timing block
`timescale 1ns/1ps
module tb_top;
    import power_mode_pkg::*;
    logic clk = 1'b0, reset = 1'b1, button_input = 1'b0, wake_timer_expired = 1'b0;
    logic sfr_write = 1'b0, sfr_read = 1'b0, keep_write = 1'b0, want_display = 1'b0;
    logic want_sleep = 1'b0, mode_change_irq, data_mem_invalid, engine_pass_start;
    logic result_write, engine_pc_clear, monitor_active, transfer_busy;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, keep_wdata = 8'h00;
    logic [7:0] sfr_rdata, keep_rdata, flags = 8'h00;
    logic [2:0] keep_sel = 3'h0;
    logic [1:0] result_slot, wake_cause;
    logic [15:0] restart_pc;
    supply_status_t supply = 5'h1f;
    fw_control_t ctrl;
    op_mode_t mode, exp_mode;
    gate_out_t gates;
    int errors = 0, tests_run = 0, n, mon, wr;
    always #4 clk = ~clk;
    meter_power_mode_and_frame_timing u_meter_power_mode_and_frame_timing (.*);
    firmware_model u_firmware_model (.want_display(want_display), .want_sleep(want_sleep),
        .flags(flags), .comparator_status(1'b0), .ctrl(ctrl), .wake_cause(wake_cause));
    task automatic complete_run;
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick;
        @(posedge clk);
        #1;
    endtask
    // bounded wait; a spent bound ends the run
    task automatic wait_mode(input op_mode_t m);
        exp_mode = m;
        for (n = 0; mode !== exp_mode && n < 20000; n++) tick();
        if (n == 20000) begin
            errors++;
            complete_run();
        end
    endtask
    task automatic sfr(input logic [7:0] a, input logic w, input logic [7:0] d);
        @(posedge clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_write <= w;
        sfr_read <= !w;
        tick();
        sfr_write <= 1'b0;
        sfr_read <= 1'b0;
        flags = sfr_rdata;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        n = $urandom(32'h56e4);
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        sfr(8'he8, 1'b0, 8'h00);
        chk(flags, 8'h00);
        // one frame measured pass start to pass start
        for (n = 0; engine_pass_start !== 1'b1 && n < 20000; n++) tick();
        chk(transfer_busy, 1'b0);
        mon = 0;
        wr = 0;
        n = 0;
        do begin
            mon += int'(monitor_active === 1'b1);
            wr += int'(result_write === 1'b1);
            tick();
            n++;
        end while (engine_pass_start !== 1'b1 && n < 20000);
        chk(16'(n), 16'(2 * CRYSTAL_DIV));
        chk(16'(mon), 16'(MONITOR_BITS));
        chk(16'(wr), 16'h1);
        chk(transfer_busy, 1'b1);
        // mains and lock lost, battery present with headroom
        supply <= 5'h06;
        wait_mode(MODE_BATTERY_RUN);
        chk(gates.adc_enable, 1'b0);
        chk(engine_pc_clear, 1'b1);
        chk(mode_change_irq, 1'b1);
        sfr(8'he8, 1'b0, 8'h00);
        chk(flags, 8'h80);
        sfr(8'h12, 1'b0, 8'h00);
        chk(flags, 8'h00);
        sfr(8'he8, 1'b1, 8'h00);
        sfr(8'he8, 1'b0, 8'h00);
        chk(flags, 8'h00);
        keep_sel <= 3'($urandom());
        keep_wdata <= 8'($urandom());
        keep_write <= 1'b1;
        tick();
        keep_write <= 1'b0;
        want_sleep <= 1'b1;
        wait_mode(MODE_SLEEP);
        want_sleep <= 1'b0;
        button_input <= 1'b1;
        wait_mode(MODE_BATTERY_RUN);
        for (n = 0; gates.processor_run !== 1'b1 && n < 3 * CRYSTAL_DIV + 2; n++) tick();
        chk(gates.processor_run, 1'b1);
        sfr(8'he8, 1'b0, 8'h00);
        chk(wake_cause, 2'h1);
        chk({data_mem_invalid, restart_pc[14:0]}, 16'h8000);
        chk(keep_rdata, keep_wdata);
        sfr(8'he8, 1'b1, 8'h00);
        button_input <= 1'b0;
        want_display <= 1'b1;
        wait_mode(MODE_DISPLAY_ONLY);
        want_display <= 1'b0;
        wake_timer_expired <= 1'b1;
        wait_mode(MODE_BATTERY_RUN);
        wake_timer_expired <= 1'b0;
        sfr(8'he8, 1'b0, 8'h00);
        chk(flags, 8'h20);
        supply <= 5'h01;
        wait_mode(MODE_SLEEP);
        supply <= 5'h03;
        repeat (50) tick();
        chk(mode, MODE_SLEEP);
        complete_run();
    end
endmodule
